// File: verilog/bpf_protect.sv
/*
 * sequencer of the two-cell protection controller with an apb slave.
 * comparator flags arrive by register or by pins, pins synchronised.
 * assumes pclk at 100 MHz and a single apb master.
 */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bpf_regs.svh"
module bpf_protect #(
   parameter int OVCHG_DET = `BPF_MS_CYC(`BPF_OVCHG_DET_MS),
   parameter int OVCHG_REL = `BPF_MS_CYC(`BPF_OVCHG_REL_MS),
   parameter int OVDSG_DET = `BPF_MS_CYC(`BPF_OVDSG_DET_MS),
   parameter int OVDSG_REL = `BPF_US_CYC(`BPF_OVDSG_REL_US),
   parameter int OVCUR_DET = `BPF_MS_CYC(`BPF_OVCUR_DET_MS),
   parameter int OVCUR_REL = `BPF_US_CYC(`BPF_OVCUR_REL_US),
   parameter int SHORT_DET = `BPF_US_CYC(`BPF_SHORT_DET_US),
   parameter int XCHG_DET  = `BPF_US_CYC(`BPF_XCHG_DET_US),
   parameter int XCHG_REL  = `BPF_US_CYC(`BPF_XCHG_REL_US),
   parameter int TEST_DIV  = `BPF_TEST_DIV
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [`BPF_COND_W-1:0] cond_pins,
   input  wire logic                 shorten_pin,
   output logic                      charge_fet_enable,
   output logic                      discharge_fet_enable,
   output logic                      pullup_resistor_select,
   output logic                      pulldown_resistor_select,
   output logic                      standby
);
   localparam int W = 28;

   // ----------------------------------------------------------------------
   // checks and helpers
   // ----------------------------------------------------------------------
   initial begin
      if (OVCHG_DET >= (1 << W)) $error("overcharge delay too long");
      if (TEST_DIV < 1) $error("test divider must be positive");
      if (SHORT_DET >= OVCUR_DET) $error("short delay must be shorter");
   end

   function automatic logic [W-1:0] lim(input int cyc, input logic tst);
      int v;
      v = tst ? cyc / TEST_DIV : cyc;
      if (v < 1) v = 1;
      lim = W'(v - 1);
   endfunction : lim

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [`BPF_COND_W:0] sync_a;
   logic [`BPF_COND_W:0] sync_b;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (ce) begin
         sync_a <= {shorten_pin, cond_pins};
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   logic [31:0]          ctrl;
   logic [`BPF_COND_W-1:0] cond_reg;
   logic [`BPF_S_W-1:0]  status;
   logic                 wr_acc;
   logic                 known;

   assign wr_acc = psel && penable && pwrite && pready;
   assign known  = (paddr == `BPF_ADDR_CTRL) || (paddr == `BPF_ADDR_COND)
                 || (paddr == `BPF_ADDR_STATUS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (ce) begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= `BPF_CTRL_RESET;
         cond_reg <= `BPF_COND_W'(`BPF_COND_RESET);
      end else if (ce && wr_acc) begin
         if (paddr == `BPF_ADDR_CTRL)
            ctrl <= pwdata & 32'h00000001;
         if (paddr == `BPF_ADDR_COND)
            cond_reg <= pwdata[`BPF_COND_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pslverr <= psel && !penable && !known;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `BPF_ADDR_CTRL:   prdata <= ctrl;
               `BPF_ADDR_COND:   prdata <= 32'(cond_reg);
               `BPF_ADDR_STATUS: prdata <= 32'(status);
               default:          prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // condition decode
   // ----------------------------------------------------------------------
   logic [`BPF_COND_W-1:0] c;
   logic tst;
   logic oc_any, ocr_any, od_any, rel_ok;

   assign c   = cond_reg | sync_b[`BPF_COND_W-1:0];
   // high shortens, low selects normal delays
   assign tst = ctrl[`BPF_CTRL_SHORTEN] | sync_b[`BPF_COND_W];
   assign oc_any  = c[`BPF_C_OC1] | c[`BPF_C_OC2];
   assign ocr_any = c[`BPF_C_OCR1] | c[`BPF_C_OCR2];
   assign od_any  = c[`BPF_C_OD1] | c[`BPF_C_OD2];
   // both cells released, load node low or loaded
   assign rel_ok  = !ocr_any && (!c[`BPF_C_OCUR] || c[`BPF_C_LOAD]);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   bpf_pkg::bpf_chg_type chg;
   logic ovdsg, ovcur, short_st, stby;
   logic d_ocd, d_ocr, d_odd, d_odr, d_cur, d_cr, d_sc, d_xd, d_xr;

   // overcharge detection delay
   bpf_delay #(.WIDTH(W)) u_ocd (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(chg == bpf_pkg::bpf_chg_on && oc_any),
      .limit(lim(OVCHG_DET, tst)), .done(d_ocd));
   bpf_delay #(.WIDTH(W)) u_ocr (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(chg == bpf_pkg::bpf_chg_ovchg && rel_ok),
      .limit(lim(OVCHG_REL, tst)), .done(d_ocr));
   // overdischarge detect and release
   bpf_delay #(.WIDTH(W)) u_odd (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(!ovdsg && od_any), .limit(lim(OVDSG_DET, tst)), .done(d_odd));
   bpf_delay #(.WIDTH(W)) u_odr (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(ovdsg && !stby && !od_any),
      .limit(lim(OVDSG_REL, tst)), .done(d_odr));
   // overcurrent held off during overcharge
   bpf_delay #(.WIDTH(W)) u_cur (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(!ovcur && !short_st && chg != bpf_pkg::bpf_chg_ovchg
            && c[`BPF_C_OCUR]),
      .limit(lim(OVCUR_DET, tst)), .done(d_cur));
   bpf_delay #(.WIDTH(W)) u_cr (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond((ovcur || short_st) && !c[`BPF_C_OCUR]),
      .limit(lim(OVCUR_REL, tst)), .done(d_cr));
   // short circuit delay ignores test mode
   bpf_delay #(.WIDTH(W)) u_sc (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(!short_st && c[`BPF_C_SHORT]),
      .limit(lim(SHORT_DET, 1'b0)), .done(d_sc));
   // excess charger count waits for overdischarge release
   bpf_delay #(.WIDTH(W)) u_xd (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(chg == bpf_pkg::bpf_chg_on && !ovdsg && c[`BPF_C_XCHG]),
      .limit(lim(XCHG_DET, tst)), .done(d_xd));
   // excess charger release delay
   bpf_delay #(.WIDTH(W)) u_xr (.pclk(pclk), .presetn(presetn), .ce(ce),
      .cond(chg == bpf_pkg::bpf_chg_xchg && !c[`BPF_C_XCHG]),
      .limit(lim(XCHG_REL, tst)), .done(d_xr));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chg <= bpf_pkg::bpf_chg_on;
      end else if (ce) begin
         case (chg)
            bpf_pkg::bpf_chg_on:
               if (d_ocd)
                  chg <= bpf_pkg::bpf_chg_ovchg;
               else if (d_xd)
                  chg <= bpf_pkg::bpf_chg_xchg;
            bpf_pkg::bpf_chg_ovchg:
               if (d_ocr)
                  // excess charger present: stay off
                  chg <= c[`BPF_C_XCHG] ? bpf_pkg::bpf_chg_xchg
                                        : bpf_pkg::bpf_chg_on;
            bpf_pkg::bpf_chg_xchg:
               if (d_xr)
                  chg <= bpf_pkg::bpf_chg_on;
            default:
               chg <= bpf_pkg::bpf_chg_on;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovdsg <= 1'b0;
         stby  <= 1'b0;
      end else if (ce) begin
         if (d_odd) begin
            ovdsg <= 1'b1;
            // no standby while overcharged
            stby  <= chg != bpf_pkg::bpf_chg_ovchg;
         end else if (stby && c[`BPF_C_STBY_REL]) begin
            stby <= 1'b0;
         end else if (d_odr) begin
            ovdsg <= 1'b0;
         end
      end
   end

   // overcurrent and short never set standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovcur    <= 1'b0;
         short_st <= 1'b0;
      end else if (ce) begin
         if (d_cr) begin
            ovcur    <= 1'b0;
            short_st <= 1'b0;
         end else begin
            if (d_cur) ovcur <= 1'b1;
            if (d_sc) short_st <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all registered
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         charge_fet_enable        <= 1'b1;
         discharge_fet_enable     <= 1'b1;
         pullup_resistor_select   <= 1'b0;
         pulldown_resistor_select <= 1'b0;
         standby                  <= 1'b0;
         status                   <= '0;
      end else if (ce) begin
         charge_fet_enable        <= chg == bpf_pkg::bpf_chg_on;
         discharge_fet_enable     <= !(ovdsg || ovcur || short_st);
         // pull-up replaces pull-down once overdischarged
         pullup_resistor_select   <= ovdsg;
         pulldown_resistor_select <= !ovdsg && (ovcur || short_st);
         standby                  <= stby;
         status <= {tst, chg == bpf_pkg::bpf_chg_xchg, short_st, ovcur,
                    ovdsg, chg == bpf_pkg::bpf_chg_ovchg, stby,
                    !ovdsg && (ovcur || short_st), ovdsg,
                    !(ovdsg || ovcur || short_st),
                    chg == bpf_pkg::bpf_chg_on};
      end
   end
endmodule : bpf_protect
`default_nettype wire

// File: verilog/bpf_regs.svh
/*
 * constants of the two-cell protection sequencer: register map, field
 * positions, reset values and delay figures.
 * assumes the includer counts delays in pclk cycles at 100 MHz.
 */
`ifndef BPF_REGS_SVH
`define BPF_REGS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define BPF_ADDR_CTRL      12'h000
`define BPF_ADDR_COND      12'h004
`define BPF_ADDR_STATUS    12'h008
`define BPF_CTRL_SHORTEN   0
`define BPF_CTRL_RESET     32'h00000000
// condition bits written by the comparator front end
`define BPF_C_OC1          0
`define BPF_C_OC2          1
`define BPF_C_OCR1         2
`define BPF_C_OCR2         3
`define BPF_C_OD1          4
`define BPF_C_OD2          5
`define BPF_C_OCUR         6
`define BPF_C_SHORT        7
`define BPF_C_STBY_REL     8
`define BPF_C_XCHG         9
`define BPF_C_LOAD         10
`define BPF_COND_RESET     32'h00000000
`define BPF_COND_W         11
// status bits
`define BPF_S_CHG_EN       0
`define BPF_S_DSG_EN       1
`define BPF_S_PULLUP       2
`define BPF_S_PULLDN       3
`define BPF_S_STANDBY      4
`define BPF_S_OVCHG        5
`define BPF_S_OVDSG        6
`define BPF_S_OVCUR        7
`define BPF_S_SHORT        8
`define BPF_S_XCHG         9
`define BPF_S_TEST         10
`define BPF_S_W            11

// ----------------------------------------------------------------------
// delay figures, in their own units, and cycle counts
// ----------------------------------------------------------------------
`define BPF_CLK_HZ         100000000
`define BPF_OVCHG_DET_MS   1000
`define BPF_OVCHG_REL_MS   40
`define BPF_OVDSG_DET_MS   100
`define BPF_OVDSG_REL_US   1000
`define BPF_OVCUR_DET_MS   20
`define BPF_OVCUR_REL_US   1000
`define BPF_SHORT_DET_US   250
`define BPF_XCHG_DET_US    1500
`define BPF_XCHG_REL_US    1500
`define BPF_MS_CYC(t)      ((t) * (`BPF_CLK_HZ / 1000))
`define BPF_US_CYC(t)      ((t) * (`BPF_CLK_HZ / 1000000))
`define BPF_TEST_DIV       1024

`endif

// File: verilog/bpf_pkg.sv
/*
 * types shared by the protection sequencer.
 * assumes nothing of its surroundings.
 */
package bpf_pkg;
   typedef enum logic [1:0] {
      bpf_chg_on,
      bpf_chg_ovchg,
      bpf_chg_xchg
   } bpf_chg_type;
endpackage : bpf_pkg

// File: verilog/bpf_delay.sv
/*
 * one detection or release delay: counts while its condition holds.
 * assumes a synchronous condition and a shared clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
module bpf_delay #(
   parameter int WIDTH = 28
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic             cond,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  done
);
   logic [WIDTH-1:0] count;

   initial begin
      if (WIDTH < 2) $error("bpf_delay width too small");
   end

   // dropped condition restarts from zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         done  <= 1'b0;
      end else if (ce) begin
         if (!cond) begin
            count <= '0;
            done  <= 1'b0;
         end else if (count >= limit) begin
            done <= 1'b1;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule : bpf_delay
`default_nettype wire

// File: verif/bpf_protect_sva.sv
/*
 * port checker of the protection sequencer, bound into bpf_protect.
 * assumes comparator flags reach cond_pins only, not the flag register.
 */
`timescale 1ns/1ps
`default_nettype none
module bpf_protect_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [10:0] cond_pins,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        charge_fet_enable,
   input wire logic        discharge_fet_enable,
   input wire logic        pullup_resistor_select,
   input wire logic        pulldown_resistor_select,
   input wire logic        standby
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   standby_fets_a: assert property (standby |->
      !discharge_fet_enable && pullup_resistor_select)
      else $error("standby without fet off and pull-up");
   pulldn_fet_a: assert property (pulldown_resistor_select |->
      !discharge_fet_enable)
      else $error("pull-down with discharge fet on");
   resistor_excl_a: assert property (!(pullup_resistor_select &&
      pulldown_resistor_select))
      else $error("both resistors selected");
   // depth 6 covers two sync flops plus the delay, state and output registers
   standby_cause_a: assert property ($rose(standby) |->
      $past(cond_pins[4] | cond_pins[5], 6))
      else $error("standby without overdischarge");
   chg_cause_a: assert property ($fell(charge_fet_enable) |->
      $past(cond_pins[0] | cond_pins[1] | cond_pins[9], 6))
      else $error("charge fet off without cause");
   dsg_cause_a: assert property ($fell(discharge_fet_enable) |->
      $past(|cond_pins[7:4], 6))
      else $error("discharge fet off without cause");
endmodule : bpf_protect_chk

bind bpf_protect bpf_protect_chk bpf_protect_chk_i (
   .pclk                     (pclk),
   .presetn                  (presetn),
   .psel                     (psel),
   .penable                  (penable),
   .cond_pins                (cond_pins),
   .pready                   (pready),
   .pslverr                  (pslverr),
   .charge_fet_enable        (charge_fet_enable),
   .discharge_fet_enable     (discharge_fet_enable),
   .pullup_resistor_select   (pullup_resistor_select),
   .pulldown_resistor_select (pulldown_resistor_select),
   .standby                  (standby)
);
`default_nettype wire

// File: verif/bpf_pack_model.sv
/*
 * cells, load and charger seen through their comparator flags.
 * assumes the bench sets the wanted cell and load conditions.
 */
`timescale 1ns/1ps
`default_nettype none
module bpf_pack_model (
   input  wire logic        pclk,
   input  wire logic [10:0] want,
   input  wire logic        charger_on,
   output logic      [10:0] cond_pins
);
   // a charger drags the charger-minus node below release level
   always_ff @(posedge pclk) begin
      cond_pins <= {want[10:9], charger_on, want[7:0]};
   end
endmodule : bpf_pack_model
`default_nettype wire

// File: verif/bpf_protect_tb_top.sv
/*
 * self-checking bench of the protection sequencer with short delays.
 * assumes pclk at 100 MHz and clock enable always high.
 */
`timescale 1ns/1ps
`default_nettype none
module bpf_protect_tb_top;
   localparam int OCD = 60, OCR = 40, ODD = 50, ODR = 20, CUD = 32;
   localparam int CUR = 24, SCD = 12, XD = 30, XR = 30, DIV = 4;
   localparam int CHG = 0, DSG = 1, PU = 2, PD = 3, SB = 4;
   logic        pclk, presetn, psel, penable, pwrite;
   logic        shorten_pin, charger_on;
   logic        pready, pslverr, chg, dsg, pu, pd, sb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [10:0] want, cond_pins;
   logic [4:0]  obs;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;

   assign obs = {sb, pd, pu, dsg, chg};

   bpf_protect #(.OVCHG_DET(OCD), .OVCHG_REL(OCR), .OVDSG_DET(ODD),
      .OVDSG_REL(ODR), .OVCUR_DET(CUD), .OVCUR_REL(CUR), .SHORT_DET(SCD),
      .XCHG_DET(XD), .XCHG_REL(XR), .TEST_DIV(DIV)) bpf_protect_i (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cond_pins(cond_pins), .shorten_pin(shorten_pin),
      .charge_fet_enable(chg), .discharge_fet_enable(dsg),
      .pullup_resistor_select(pu), .pulldown_resistor_select(pd),
      .standby(sb));
   bpf_pack_model bpf_pack_model_i (.pclk(pclk), .want(want),
      .charger_on(charger_on), .cond_pins(cond_pins));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   // test mode shortens every counted delay except the short-circuit delay by the same factor
   function automatic int lim(input int base, input int t);
      return (t != 0) ? base / DIV : base;
   endfunction : lim

   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic chk_win(input string what, input int lo, input int hi,
                          input int got);
      n_compared++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_win

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   // margin covers model register, pin sync and state registers
   task automatic wait_obs(input int idx, input logic val, input int lo);
      int n;
      n = 0;
      while (obs[idx] !== val && n < lo + 30) begin
         @(posedge pclk);
         n++;
      end
      chk_win($sformatf("delay of output %0d", idx), lo, lo + 12, n);
   endtask : wait_obs

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed: only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic [31:0] r;
      logic        e;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      shorten_pin = 1'b0;
      charger_on = 1'b0;
      want = 11'h000;
      seed = 32'h41;
      idle(8);
      presetn <= 1'b1;
      idle(1);
      chk("outputs after reset", 5'h03, obs);
      apb(1'b0, 12'h000, 32'h0, q, e);
      chk("ctrl reset", 32'h0, q);
      r = xs();
      apb(1'b1, 12'h000, r, q, e);
      apb(1'b0, 12'h000, 32'h0, q, e);
      chk("ctrl readback", {31'h0, r[0]}, q);
      apb(1'b1, 12'h000, 32'h1, q, e);
      apb(1'b0, 12'h008, 32'h0, q, e);
      chk("status test bit", 32'h1, (q >> 10) & 32'h1);
      apb(1'b1, 12'h000, 32'h0, q, e);
      apb(1'b0, 12'h00C, 32'h0, q, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      // overcharge with a short glitch first, then short while overcharged
      want[0] <= 1'b1;
      want[2] <= 1'b1;
      idle(2 + int'(xs() % 29));
      want[0] <= 1'b0;
      idle(10);
      chk("charge fet after glitch", 32'h1, obs[CHG]);
      want[0] <= 1'b1;
      wait_obs(CHG, 1'b0, OCD);
      want[6] <= 1'b1;
      idle(CUD + 20);
      chk("overcurrent blocked", 32'h1, obs[DSG]);
      want[7] <= 1'b1;
      wait_obs(DSG, 1'b0, SCD);
      idle(2);
      chk("short pull-down", 32'h1, obs[PD]);
      want[7:6] <= 2'b00;
      wait_obs(DSG, 1'b1, CUR);
      // cells released but load node high with no load: stays off
      want[6] <= 1'b1;
      want[0] <= 1'b0;
      want[2] <= 1'b0;
      idle(OCR + 20);
      chk("charge fet held by load node", 32'h0, obs[CHG]);
      want[10] <= 1'b1;
      wait_obs(CHG, 1'b1, OCR);
      want[6] <= 1'b0;
      want[10] <= 1'b0;
      // excess charger present when overcharge releases
      want[0] <= 1'b1;
      want[2] <= 1'b1;
      wait_obs(CHG, 1'b0, OCD);
      want[9] <= 1'b1;
      want[0] <= 1'b0;
      want[2] <= 1'b0;
      idle(OCR + XD + 20);
      chk("charge fet held off", 32'h0, obs[CHG]);
      want[9] <= 1'b0;
      wait_obs(CHG, 1'b1, XR);
      // overdischarge into standby, left only by a charger
      want[4] <= 1'b1;
      wait_obs(DSG, 1'b0, ODD);
      idle(2);
      chk("standby and pull-up", 5'h14, obs & 5'h1E);
      want[4] <= 1'b0;
      want[9] <= 1'b1;
      idle(40);
      chk("standby kept", 32'h1, obs[SB]);
      charger_on <= 1'b1;
      wait_obs(DSG, 1'b1, ODR);
      chk("standby left", 32'h0, obs[SB]);
      chk("excess charger held off", 32'h1, obs[CHG]);
      wait_obs(CHG, 1'b0, XD);
      want[9] <= 1'b0;
      wait_obs(CHG, 1'b1, XR);
      charger_on <= 1'b0;
      // overcurrent in normal and shortened-delay mode
      for (int t = 0; t < 2; t++) begin
         shorten_pin <= t[0];
         idle(4);
         want[6] <= 1'b1;
         wait_obs(DSG, 1'b0, lim(CUD, t));
         idle(2);
         chk("overcurrent outputs", 5'h08, obs & 5'h1E);
         want[6] <= 1'b0;
         wait_obs(DSG, 1'b1, lim(CUR, t));
      end
      shorten_pin <= 1'b0;
      idle(4);
      conclude();
   end
endmodule : bpf_protect_tb_top
`default_nettype wire
